// ---- src/rdsx_decode.sv ----
// Combinational sign source selection and fill enable decode.
// Assumes all inputs are stable within one microcycle.
`timescale 1ns/1ps
`default_nettype none
`include "rdsx_map.svh"
module rdsx_decode (
    input  wire rdsx_pkg::rdsx_minst_t minst,
    input  wire logic [7:0]            src_addr,
    input  wire logic [2:0]            move_path_function,
    input  wire logic [1:0]            transfer_size_reg,
    input  wire logic                  data_req,
    input  wire logic [15:0]           memory_controller_bus,
    input  wire logic [7:0]            operand_shift_reg,
    output logic                       fill_upper,
    output logic                       fill_second,
    output logic                       sign_bit,
    output logic                       xcvr_hi_en,
    output logic                       xcvr_b1_en
);
    import rdsx_pkg::*;

    // Low seven address bits fall in the discrete register window
    function automatic logic in_discrete(input logic [7:0] a);
        in_discrete = (a[6:0] >= `RDSX_DISC_LO) && (a[6:0] <= `RDSX_DISC_HI);
    endfunction

    logic rd_move;
    logic [1:0] fc;

    // Sign source multiplexer
    always_comb begin
        sign_bit = operand_shift_reg[7];                       // RULE6 RULE8 RULE4
        if (minst == RDSX_MI_MOVE && data_req) begin
            sign_bit = transfer_size_reg[0] ? memory_controller_bus[15]   // RULE7 RULE2
                                            : memory_controller_bus[7];   // RULE7 RULE1
        end
    end

    // Fill enable decode; anything unlisted leaves both off
    always_comb begin
        fill_upper  = 1'b0;                                    // RULE12
        fill_second = 1'b0;                                    // RULE12
        fc          = move_path_function[1:0];
        rd_move     = 1'b0;
        case (minst)
            RDSX_MI_GENERAL: begin
                if (!src_addr[7] && in_discrete(src_addr)) begin   // RULE9
                    fill_upper  = 1'b1;
                    fill_second = 1'b1;
                end
            end
            RDSX_MI_MOVE: begin
                case (fc)
                    2'b11: begin
                        if (in_discrete(src_addr)) begin       // RULE10
                            fill_upper  = 1'b1;
                            fill_second = 1'b1;
                        end
                    end
                    2'b10: begin
                        if (!src_addr[7]) begin                // RULE10 RULE4
                            fill_upper  = 1'b1;
                            fill_second = 1'b1;
                        end
                    end
                    2'b00: begin
                        rd_move = 1'b1;
                        case (transfer_size_reg)
                            RDSX_SZ_BYTE: begin                // RULE11 RULE1
                                fill_upper  = 1'b1;
                                fill_second = 1'b1;
                            end
                            RDSX_SZ_WORD: begin                // RULE11 RULE2
                                fill_upper  = 1'b1;
                            end
                            default: begin                     // RULE11
                                fill_upper  = 1'b0;
                            end
                        endcase
                    end
                    default: begin
                        fill_upper = 1'b0;
                    end
                endcase
            end
            default: begin
                fill_upper = 1'b0;
            end
        endcase
    end

    // Memory transceiver enables for the high lines
    always_comb begin
        xcvr_hi_en = !(rd_move && transfer_size_reg != RDSX_SZ_LONG);  // RULE3
        xcvr_b1_en = !(rd_move && transfer_size_reg == RDSX_SZ_BYTE);  // RULE3
    end

endmodule // rdsx_decode
`default_nettype wire

// ---- src/rdsx_map.svh ----
// Address map, field positions, reset values and decode constants
// for the read-data sign extender. Definitions only.
//
// Summary of operation
// RULE1: Byte read on lines 7..0 copies line 7 onto lines 31..8.
// RULE2: Word read on lines 15..0 copies line 15 onto lines 31..16.
// RULE3: High-order memory transceivers are off during byte and word reads.
// RULE4: Reading the operand shift register fills high lines from its bit 7.
// RULE5: Two separately enabled drive groups: bits 31..16 and bits 15..8.
// RULE6: General microinstruction always takes operand shift bit 7 as sign.
// RULE7: Transfer with request takes bus bit 7 (size0=0) or 15 (size0=1).
// RULE8: Transfer without request takes operand shift bit 7 as sign.
// RULE9: General microinstruction fills both groups for 7C..7F, none for 00..7B.
// RULE10: Transfer code 3/7 with 7C..7F or FC..FF, or 2/6 with 00..7F: fill both.
// RULE11: Transfer code 0/4: size 00 fills both, 01 upper only, 11 none.
// RULE12: With no enable set, both groups float and leave the bus alone.
`ifndef RDSX_MAP_SVH
`define RDSX_MAP_SVH

// Register byte offsets
`define RDSX_OFS_CTRL       8'h00
`define RDSX_OFS_STATUS     8'h04
`define RDSX_OFS_FILLCNT    8'h08
`define RDSX_OFS_LASTOP     8'h0C

// Control fields and reset value
`define RDSX_CTRL_FILL_EN   0
`define RDSX_CTRL_RESET     32'h0000_0001

// Status fields
`define RDSX_ST_UPPER       0
`define RDSX_ST_SECOND      1
`define RDSX_ST_SIGN        2
`define RDSX_ST_XCVR_HI     3
`define RDSX_ST_XCVR_B1     4

// Last-operation capture fields
`define RDSX_LO_ADDR_LSB    0
`define RDSX_LO_FUNC_LSB    8
`define RDSX_LO_SIZE_LSB    12
`define RDSX_LO_REQ         14

// Discrete register address window, low seven bits
`define RDSX_DISC_LO        7'h7C
`define RDSX_DISC_HI        7'h7F

`endif

// ---- src/rdsx_pkg.sv ----
// Types shared by the sign extender design files.
// Assumes nothing of its surroundings.
package rdsx_pkg;

    // Kind of microinstruction in the current microcycle
    typedef enum logic [2:0] {
        RDSX_MI_GENERAL = 3'b001,
        RDSX_MI_MOVE    = 3'b010,
        RDSX_MI_OTHER   = 3'b100
    } rdsx_minst_t;

    // Bus data-phase kind
    typedef enum logic [2:0] {
        RDSX_DP_IDLE  = 3'b001,
        RDSX_DP_WRITE = 3'b010,
        RDSX_DP_READ  = 3'b100
    } rdsx_dphase_t;

    // Transfer size register encodings
    typedef enum logic [1:0] {
        RDSX_SZ_BYTE = 2'b00,
        RDSX_SZ_WORD = 2'b01,
        RDSX_SZ_RSVD = 2'b10,
        RDSX_SZ_LONG = 2'b11
    } rdsx_size_t;

endpackage

// ---- src/rdsx_top.sv ----
// Read-data sign extender with AHB-Lite register access.
// Assumes microinstruction inputs are synchronous to hclk, one
// microcycle per clock; the drive groups are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "rdsx_map.svh"
module rdsx_top #(
    parameter int OS_W = 8,
    parameter int MC_W = 16
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Microinstruction context
    input  wire rdsx_pkg::rdsx_minst_t minst,
    input  wire logic [7:0]            src_addr,
    input  wire logic [2:0]            move_path_function,
    input  wire logic [1:0]            transfer_size_reg,
    input  wire logic                  data_req,
    input  wire logic [MC_W-1:0]       memory_controller_bus,
    input  wire logic [OS_W-1:0]       operand_shift_reg,
    // Fill drive groups
    output logic                       fill_upper_half_enable,
    output logic                       fill_second_byte_enable,
    output logic [15:0]                src_bus_hi_out,
    output logic                       src_bus_hi_oe,
    output logic [7:0]                 src_bus_b1_out,
    output logic                       src_bus_b1_oe,
    // Memory transceiver enables
    output logic                       xcvr_hi_en,
    output logic                       xcvr_b1_en
);
    import rdsx_pkg::*;

    // Elaboration check on parameters
    if (OS_W != 8 || MC_W != 16) begin : g_bad_width
        $error("rdsx_top: OS_W must be 8 and MC_W must be 16");
    end

    // Decoder results
    logic dec_upper;
    logic dec_second;
    logic dec_sign;
    logic dec_xhi;
    logic dec_xb1;

    // Register state
    logic [31:0]  ctrl_q;
    logic [31:0]  fill_cnt_q;
    logic [31:0]  last_op_q;
    logic         upper_q;
    logic         second_q;
    logic         sign_q;
    logic         xhi_q;
    logic         xb1_q;
    logic [15:0]  hi_out_q;
    logic         hi_oe_q;
    logic [7:0]   b1_out_q;
    logic         b1_oe_q;

    // Bus state
    rdsx_dphase_t dphase_q;
    logic [7:0]   daddr_q;
    logic [31:0]  hrdata_q;
    logic         hreadyout_q;
    logic         take;
    logic         wr_ctrl;
    logic         wr_cnt;
    logic         fill_gate;
    logic         any_fill;
    logic [31:0]  ctrl_view;

    // Mapped offset test
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `RDSX_OFS_CTRL) || (a == `RDSX_OFS_STATUS) ||
                    (a == `RDSX_OFS_FILLCNT) || (a == `RDSX_OFS_LASTOP);
    endfunction

    // Sign source and enable decode
    rdsx_decode u_decode (
        .minst                 (minst),
        .src_addr              (src_addr),
        .move_path_function    (move_path_function),
        .transfer_size_reg     (transfer_size_reg),
        .data_req              (data_req),
        .memory_controller_bus (memory_controller_bus[15:0]),
        .operand_shift_reg     (operand_shift_reg[7:0]),
        .fill_upper            (dec_upper),
        .fill_second           (dec_second),
        .sign_bit              (dec_sign),
        .xcvr_hi_en            (dec_xhi),
        .xcvr_b1_en            (dec_xb1)
    );

    // Software gate on the fill drive
    assign fill_gate = ctrl_q[`RDSX_CTRL_FILL_EN];
    assign any_fill  = fill_gate && (dec_upper || dec_second);

    // Latch enables and sign once per microcycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_q  <= 1'b0;
            second_q <= 1'b0;
            sign_q   <= 1'b0;
        end else begin
            upper_q  <= fill_gate && dec_upper;               // RULE5
            second_q <= fill_gate && dec_second;              // RULE5
            sign_q   <= dec_sign;
        end
    end

    // Upper group drive, bits 31..16
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_out_q <= 16'h0000;
            hi_oe_q  <= 1'b0;
        end else begin
            hi_out_q <= {16{dec_sign}};                       // RULE1 RULE2 RULE4
            hi_oe_q  <= fill_gate && dec_upper;               // RULE5 RULE12
        end
    end

    // Second byte group drive, bits 15..8
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b1_out_q <= 8'h00;
            b1_oe_q  <= 1'b0;
        end else begin
            b1_out_q <= {8{dec_sign}};                        // RULE1 RULE4
            b1_oe_q  <= fill_gate && dec_second;              // RULE5 RULE12
        end
    end

    // Transceiver enables, off for high lines of short reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xhi_q <= 1'b1;
            xb1_q <= 1'b1;
        end else begin
            xhi_q <= dec_xhi;                                 // RULE3
            xb1_q <= dec_xb1;                                 // RULE3
        end
    end

    // Address phase qualifier
    assign take    = hsel && htrans[1] && hready;
    assign wr_ctrl = (dphase_q == RDSX_DP_WRITE) && (daddr_q == `RDSX_OFS_CTRL);
    assign wr_cnt  = (dphase_q == RDSX_DP_WRITE) && (daddr_q == `RDSX_OFS_FILLCNT);

    // Data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_q <= RDSX_DP_IDLE;
            daddr_q  <= 8'h00;
        end else if (take) begin
            dphase_q <= hwrite ? RDSX_DP_WRITE : RDSX_DP_READ;
            daddr_q  <= {haddr[7:2], 2'b00};
        end else begin
            dphase_q <= RDSX_DP_IDLE;
        end
    end

    // Control register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `RDSX_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= {31'h0000_0000, hwdata[`RDSX_CTRL_FILL_EN]};
        end
    end

    // Fill event counter; a count during a software clear loads one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fill_cnt_q <= 32'h0000_0000;
        end else if (any_fill) begin
            fill_cnt_q <= wr_cnt ? 32'h0000_0001 : fill_cnt_q + 32'h0000_0001;
        end else if (wr_cnt) begin
            fill_cnt_q <= 32'h0000_0000;
        end
    end

    // Capture of the last microcycle that drove a fill
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_op_q <= 32'h0000_0000;
        end else if (any_fill) begin
            last_op_q <= {17'h0_0000, data_req, transfer_size_reg,
                          1'b0, move_path_function, src_addr};
        end
    end

    // Control view with a write in flight forwarded
    assign ctrl_view = wr_ctrl ? {31'h0000_0000, hwdata[`RDSX_CTRL_FILL_EN]} : ctrl_q;

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case ({haddr[7:2], 2'b00})
                `RDSX_OFS_CTRL:    hrdata_q <= ctrl_view;
                `RDSX_OFS_STATUS:  hrdata_q <= {27'h000_0000, xb1_q, xhi_q,
                                               sign_q, second_q, upper_q};
                `RDSX_OFS_FILLCNT: hrdata_q <= fill_cnt_q;
                `RDSX_OFS_LASTOP:  hrdata_q <= last_op_q;
                default:           hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    // Output assignments straight from flops, except hresp tied low
    assign hrdata                  = hrdata_q;
    assign hreadyout               = hreadyout_q;
    assign hresp                   = 1'b0;
    assign fill_upper_half_enable  = upper_q;
    assign fill_second_byte_enable = second_q;
    assign src_bus_hi_out          = hi_out_q;
    assign src_bus_hi_oe           = hi_oe_q;
    assign src_bus_b1_out          = b1_out_q;
    assign src_bus_b1_oe           = b1_oe_q;
    assign xcvr_hi_en              = xhi_q;
    assign xcvr_b1_en              = xb1_q;

endmodule // rdsx_top
`default_nettype wire

// ---- tb/rdsx_checker.sv ----
// Property checker bound to the sign extender top.
// Assumes CTRL is rewritten only while no fill is decoded.
`timescale 1ns/1ps
`default_nettype none
module rdsx_checker
    import rdsx_pkg::*;
#(
    parameter int OS_W = 8,
    parameter int MC_W = 16
) (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic [31:0]           hwdata,
    input wire rdsx_pkg::rdsx_minst_t minst,
    input wire logic [7:0]            src_addr,
    input wire logic [2:0]            move_path_function,
    input wire logic [1:0]            transfer_size_reg,
    input wire logic                  data_req,
    input wire logic [MC_W-1:0]       memory_controller_bus,
    input wire logic [OS_W-1:0]       operand_shift_reg,
    input wire logic                  fill_upper_half_enable,
    input wire logic                  fill_second_byte_enable,
    input wire logic [15:0]           src_bus_hi_out,
    input wire logic                  src_bus_hi_oe,
    input wire logic [7:0]            src_bus_b1_out,
    input wire logic                  src_bus_b1_oe,
    input wire logic                  xcvr_hi_en,
    input wire logic                  xcvr_b1_en
);
    logic       live_q, wr_q, gate_q, eu, es, sg, xh, xb;
    logic [1:0] c;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Reset release and fill gate seen over the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_q <= 1'b0;
            wr_q   <= 1'b0;
            gate_q <= 1'b1;
        end else begin
            live_q <= 1'b1;
            wr_q   <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
            if (wr_q && hready) gate_q <= hwdata[0];
        end
    end
    // Expected decode of the present inputs
    always_comb begin
        c  = move_path_function[1:0];
        sg = (minst == RDSX_MI_MOVE && data_req) ? memory_controller_bus[transfer_size_reg[0] ? 15 : 7]
                                                 : operand_shift_reg[7];
        xh = 1'b1;
        xb = 1'b1;
        eu = 1'b0;
        if (minst == RDSX_MI_GENERAL) eu = !src_addr[7] && src_addr[6:2] == 5'h1F;
        if (minst == RDSX_MI_MOVE && c == 2'b11) eu = src_addr[6:2] == 5'h1F;
        if (minst == RDSX_MI_MOVE && c == 2'b10) eu = !src_addr[7];
        es = eu;
        if (minst == RDSX_MI_MOVE && c == 2'b00) begin
            eu = !transfer_size_reg[1];
            es = transfer_size_reg == RDSX_SZ_BYTE;
            xh = transfer_size_reg == RDSX_SZ_LONG;
            xb = transfer_size_reg != RDSX_SZ_BYTE;
        end
    end
    upper_enable_a: assert property (live_q |-> fill_upper_half_enable == $past(eu && gate_q))
        else $error("upper fill enable wrong");
    second_enable_a: assert property (live_q |-> fill_second_byte_enable == $past(es && gate_q))
        else $error("second byte fill enable wrong");
    group_oe_a: assert property (src_bus_hi_oe == fill_upper_half_enable && src_bus_b1_oe == fill_second_byte_enable)
        else $error("drive group enable mismatch");
    hi_sign_a: assert property (live_q && src_bus_hi_oe |-> src_bus_hi_out == {16{$past(sg)}})
        else $error("upper fill value wrong");
    b1_sign_a: assert property (live_q && src_bus_b1_oe |-> src_bus_b1_out == {8{$past(sg)}})
        else $error("second byte fill value wrong");
    float_idle_a: assert property (live_q && !$past(eu && gate_q) |-> !src_bus_hi_oe && !src_bus_b1_oe)
        else $error("group driven without enable");
    xcvr_hi_a: assert property (live_q |-> xcvr_hi_en == $past(xh))
        else $error("upper transceiver enable wrong");
    xcvr_b1_a: assert property (live_q |-> xcvr_b1_en == $past(xb))
        else $error("second byte transceiver enable wrong");
    word_fill_a: assert property (minst == RDSX_MI_MOVE && c == 2'b00 && transfer_size_reg == RDSX_SZ_WORD
        && data_req && gate_q |=> src_bus_hi_oe && !src_bus_b1_oe && !xcvr_hi_en
        && src_bus_hi_out == {16{$past(memory_controller_bus[15])}})
        else $error("word read fill wrong");
endmodule // rdsx_checker
bind rdsx_top rdsx_checker #(.OS_W(OS_W), .MC_W(MC_W)) chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .minst, .src_addr, .move_path_function, .transfer_size_reg, .data_req, .memory_controller_bus,
    .operand_shift_reg, .fill_upper_half_enable, .fill_second_byte_enable, .src_bus_hi_out, .src_bus_hi_oe,
    .src_bus_b1_out, .src_bus_b1_oe, .xcvr_hi_en, .xcvr_b1_en);
`default_nettype wire

// ---- tb/rdsx_mem_model.sv ----
// Memory controller model driving read data on the low bus lines.
// Assumes the bench raises drive whenever it sets the data request, for any microinstruction.
`timescale 1ns/1ps
`default_nettype none
module rdsx_mem_model (
    input  wire logic        hclk,
    input  wire logic        drive,
    input  wire logic [15:0] value,
    output logic [15:0]      bus
);
    logic [15:0] last_q = 16'h5A5A;
    // Released lines show the inverse of the last data
    always @(posedge hclk) begin
        if (drive) last_q <= value;
    end
    assign bus = drive ? value : ~last_q;
endmodule // rdsx_mem_model
`default_nettype wire

// ---- tb/test_read_data_sign_extender.sv ----
// Self-checking bench for the read-data sign extender.
// Assumes a zero-wait register slave and one-cycle fill decode.
`timescale 1ns/1ps
`default_nettype none
module test_read_data_sign_extender;
    import rdsx_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, data_req = 1'b0, mem_drv = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rng = 32'hC9C0C80F, rd, exp_q, hrdata;
    logic [15:0] mem_val = 16'h0, mem_bus, hi_out;
    logic [7:0]  src_addr = 8'h00, shift_val = 8'h00, b1_out;
    logic [2:0]  hsize = 3'h2, mpf = 3'h0;
    logic [1:0]  htrans = 2'b00, tsz = 2'b00;
    logic        hreadyout, hresp, up, sec, hi_oe, b1_oe, xh, xb, pend = 1'b0;
    rdsx_minst_t minst = RDSX_MI_OTHER;
    rdsx_minst_t kinds [3] = '{RDSX_MI_GENERAL, RDSX_MI_MOVE, RDSX_MI_OTHER};
    logic [7:0]  ads [7] = '{8'h00, 8'h7B, 8'h7C, 8'h7F, 8'h80, 8'hFC, 8'hFF};
    int          errors = 0, total_checks = 0;

    rdsx_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .minst, .src_addr, .move_path_function(mpf), .transfer_size_reg(tsz), .data_req,
        .memory_controller_bus(mem_bus), .operand_shift_reg(shift_val), .fill_upper_half_enable(up),
        .fill_second_byte_enable(sec), .src_bus_hi_out(hi_out), .src_bus_hi_oe(hi_oe), .src_bus_b1_out(b1_out),
        .src_bus_b1_oe(b1_oe), .xcvr_hi_en(xh), .xcvr_b1_en(xb));
    rdsx_mem_model mem (.hclk, .drive(mem_drv), .value(mem_val), .bus(mem_bus));

    // Free-running 8 ns clock
    initial forever #4 hclk = ~hclk;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Expected enables, transceivers and fill for one microcycle
    function automatic logic [31:0] model(rdsx_minst_t k, logic [7:0] a, logic [2:0] f, logic [1:0] z,
                                          logic r, logic [7:0] o, logic [15:0] m, logic g);
        logic u, s, h, b, sg, rd0;
        rd0 = k == RDSX_MI_MOVE && f[1:0] == 2'b00;
        sg = (k == RDSX_MI_MOVE && r) ? m[z[0] ? 15 : 7] : o[7];
        h = !rd0 || z == 2'b11;
        b = !rd0 || z != 2'b00;
        u = k == RDSX_MI_GENERAL && a[7:2] == 6'h1F;
        if (k == RDSX_MI_MOVE && f[1:0] == 2'b11) u = a[6:2] == 5'h1F;
        if (k == RDSX_MI_MOVE && f[1:0] == 2'b10) u = !a[7];
        s = u;
        if (rd0) u = !z[1];
        if (rd0) s = z == 2'b00;
        u = u & g;
        s = s & g;
        return {2'b00, u, s, u, s, h, b, {16{sg & u}}, {8{sg & s}}};
    endfunction

    function automatic logic [31:0] obs();
        return {2'b00, up, sec, hi_oe, b1_oe, xh, xb, hi_oe ? hi_out : 16'h0000, b1_oe ? b1_out : 8'h00};
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic ahb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask

    // Drive one microcycle, check the previous one back to back
    task automatic step(rdsx_minst_t k, logic [7:0] a, logic [2:0] f, logic [1:0] z, logic dr, logic g);
        logic [31:0] r;
        r = xs();
        @(posedge hclk);
        minst <= k;
        src_addr <= a;
        mpf <= f;
        tsz <= z;
        data_req <= dr;
        mem_drv <= dr;
        mem_val <= r[15:0];
        shift_val <= r[23:16];
        #1;
        if (pend) chk("fill", exp_q, obs());
        exp_q = model(k, a, f, z, dr, r[23:16], r[15:0], g);
        pend = 1'b1;
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("reset outputs", 32'h0300_0000, obs());
        chk("response", 32'h1, {30'h0, hresp, hreadyout});
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk("ctrl reset", 32'h1, rd);
        ahb(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        for (int k = 0; k < 3; k++)
            for (int f = 0; f < 8; f++)
                for (int z = 0; z < 4; z++)
                    for (int a = 0; a < 14; a++)
                        step(kinds[k], ads[a % 7], f[2:0], z[1:0], a > 6, 1'b1);
        for (int i = 0; i < 1500; i++) begin
            rd = xs();
            step(kinds[rd[9:8] % 2'd3], rd[7:0], rd[12:10], rd[14:13], rd[15], 1'b1);
        end
        repeat (2) step(RDSX_MI_OTHER, 8'h00, 3'h0, 2'b00, 1'b0, 1'b1);
        ahb(1'b1, 8'h00, 32'h0, rd);
        for (int i = 0; i < 200; i++) begin
            rd = xs();
            step(kinds[rd[9:8] % 2'd3], rd[7:0], rd[12:10], rd[14:13], rd[15], 1'b0);
        end
        repeat (2) step(RDSX_MI_OTHER, 8'h00, 3'h0, 2'b00, 1'b0, 1'b0);
        ahb(1'b1, 8'h00, 32'h1, rd);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk("ctrl readback", 32'h1, rd);
        step(RDSX_MI_MOVE, 8'h00, 3'h4, 2'b01, 1'b1, 1'b1);
        step(RDSX_MI_OTHER, 8'h00, 3'h0, 2'b00, 1'b0, 1'b1);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        chk("last fill capture", 32'h5400, rd);
        ahb(1'b0, 8'h04, 32'h0, rd);
        chk("status", {27'h0, 2'b11, shift_val[7], 2'b00}, rd);
        // Hold a filling microcycle so the clear meets a count
        step(RDSX_MI_GENERAL, 8'h7C, 3'h0, 2'b00, 1'b0, 1'b1);
        ahb(1'b1, 8'h08, 32'h0, rd);
        ahb(1'b0, 8'h08, 32'h0, rd);
        chk("fill count", 32'h2, rd);
        step(RDSX_MI_OTHER, 8'h00, 3'h0, 2'b00, 1'b0, 1'b1);
        stop_test();
    end
endmodule // test_read_data_sign_extender
`default_nettype wire
